/* verilog/sdg_pkg.sv */
package sdg_pkg;
    // =====================================================
    // register offsets (byte addresses in config space)
    localparam logic [7:0]  DBG_CTRL_OFS     = 8'h9c;
    localparam logic [7:0]  DBG_DATA_OFS     = 8'hac;
    localparam logic [7:0]  CAP_HDR_OFS      = 8'hb0;
    localparam logic [7:0]  SS_IDENT_OFS     = 8'hb4;
    localparam logic [7:0]  PIN_CTRL_OFS     = 8'hb8;
    // =====================================================
    // debug control fields
    localparam int          DBG_SRC_LSB      = 0;
    localparam int          DBG_TRIG_LSB     = 2;
    localparam int          DBG_CLR_BIT      = 6;
    localparam int          DBG_CTRL_W       = 7;
    localparam logic [6:0]  DBG_CTRL_RST     = 7'h00;
    // =====================================================
    // capability header constants
    localparam logic [7:0]  CAP_ID_VAL       = 8'h0d;
    localparam logic [7:0]  CAP_NEXT_RST     = 8'hc0;
    // =====================================================
    // pin control layout: four bits per pin
    localparam int          PIN_IN_BIT       = 0;
    localparam int          PIN_OE_BIT       = 1;
    localparam int          PIN_OUT_BIT      = 2;
    localparam int          PIN_STRIDE       = 4;
    localparam logic [7:0]  PIN_OE_RST       = 8'h00;
    localparam logic [7:0]  PIN_OUT_RST      = 8'h00;
    // =====================================================
    // training states used as trigger codes
    typedef enum logic [3:0] {
        SDG_ST_NONE     = 4'h0,
        SDG_ST_DETECT   = 4'h1,
        SDG_ST_POLLING  = 4'h2,
        SDG_ST_CONFIG   = 4'h3,
        SDG_ST_L0       = 4'h4,
        SDG_ST_L0S      = 4'h5,
        SDG_ST_L1       = 4'h6,
        SDG_ST_L2       = 4'h7,
        SDG_ST_DISABLE  = 4'h8,
        SDG_ST_HOTRST   = 4'h9,
        SDG_ST_LOOPBACK = 4'ha,
        SDG_ST_RECOVERY = 4'hb
    } sdg_state_t;
endpackage : sdg_pkg

/* verilog/sdg_regs.sv */
`timescale 1ns/1ns
// How it works
// R1: debug control at 9Ch, source select bits 1:0
// R2: trigger select bits 5:2 picks training state
// R3: clear bit 6 empties the trace buffer
// R4: trace data at ACh readable over sideband only
// R5: capability header returns identifier 0Dh
// R6: next pointer bits 15:8 read C0h
// R7: vendor code bits 15:0, sideband/eeprom loadable
// R8: device code bits 31:16, sideband/eeprom loadable
// R9: pin control at B8h only on upstream port
// R10: input bits mirror sampled pin level
// R11: output-enable bits select pin direction
// R12: output-value bits drive enabled pins
// R13: reserved bits carry no function
// R14: same four-bit pattern for pins 4 to 7
// R15: reserved bits read zero, writes ignored
// R16: trigger state starts capture of chosen source
module sdg_regs #(
    parameter int          DEPTH       = 16,
    parameter int          NPIN        = 8,
    parameter bit          IS_UPSTREAM = 1'b1,
    parameter logic [15:0] VENDOR_RST  = 16'h5a5a, // arbitrary value
    parameter logic [15:0] DEVICE_RST  = 16'ha5a5  // arbitrary value
) (
    input  wire logic               i_clk_sys,      // core clock
    input  wire logic               i_rst_n,        // sync reset, active low
    input  wire logic               i_cfg_req,      // config access strobe
    input  wire logic               i_cfg_wr,       // config write when high
    input  wire logic [7:0]         i_cfg_addr,     // config byte address
    input  wire logic [31:0]        i_cfg_wdata,    // config write data
    output logic      [31:0]        o_cfg_rdata,    // config read data
    output logic                    o_cfg_ack,      // config answer pulse
    input  wire logic               i_smb_req,      // sideband access strobe
    input  wire logic               i_smb_wr,       // sideband write when high
    input  wire logic [7:0]         i_smb_addr,     // sideband byte address
    input  wire logic [31:0]        i_smb_wdata,    // sideband write data
    output logic      [31:0]        o_smb_rdata,    // sideband read data
    output logic                    o_smb_ack,      // sideband answer pulse
    input  wire logic               i_ee_load,      // eeprom identity load
    input  wire logic [31:0]        i_ee_ident,     // eeprom identity word
    input  wire logic [3:0]         i_link_state,   // current training state
    input  wire logic [127:0]       i_trace_src,    // four trace sources
    input  wire logic [NPIN-1:0]    i_gpio_in,      // pin levels
    output logic      [NPIN-1:0]    o_gpio_out,     // pin drive value
    output logic      [NPIN-1:0]    o_gpio_oe       // pin drive enable
);
    localparam int AW = $clog2(DEPTH);

    // =====================================================
    // state
    logic [6:0]      dbg_ctrl_reg,  dbg_ctrl_next;
    logic [31:0]     ss_id_reg,     ss_id_next;
    logic [NPIN-1:0] oe_reg,        oe_next;
    logic [NPIN-1:0] out_reg,       out_next;
    logic [NPIN-1:0] pin_in_reg,    pin_in_next;
    logic [NPIN-1:0] sync1_reg, sync2_reg, sync3_reg;
    logic            armed_reg,     armed_next;
    logic [AW-1:0]   wr_ptr_reg,    wr_ptr_next;
    logic [AW-1:0]   rd_ptr_reg,    rd_ptr_next;
    logic [AW:0]     cnt_reg,       cnt_next;
    logic [31:0]     cfg_rd_reg,    cfg_rd_next;
    logic [31:0]     smb_rd_reg,    smb_rd_next;
    logic            cfg_ack_reg,   smb_ack_reg;
    logic [31:0]     trace_mem [DEPTH];

    logic            push, pop, full, empty, trig_hit;
    logic [31:0]     trace_word;
    logic            cfg_wr, smb_wr;

    assign cfg_wr = i_cfg_req && i_cfg_wr;
    assign smb_wr = i_smb_req && i_smb_wr;
    assign full   = (cnt_reg == (AW+1)'(DEPTH));
    assign empty  = (cnt_reg == '0);

    // =====================================================
    // common read view; trace data only when the caller is the sideband
    function automatic logic [31:0] rd_view(input logic [7:0] a, input logic sideband);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            sdg_pkg::DBG_CTRL_OFS: v = {25'h0, dbg_ctrl_reg};                      // R15
            // words still counted while clear takes hold are stale, so they stay hidden
            sdg_pkg::DBG_DATA_OFS: v = (sideband && !empty && !dbg_ctrl_reg[sdg_pkg::DBG_CLR_BIT])
                                       ? trace_mem[rd_ptr_reg]
                                                            : 32'h0000_0000;       // R4
            sdg_pkg::CAP_HDR_OFS:  v = {16'h0000, sdg_pkg::CAP_NEXT_RST,
                                        sdg_pkg::CAP_ID_VAL};                      // R5 R6
            sdg_pkg::SS_IDENT_OFS: v = ss_id_reg;                                  // R7 R8
            sdg_pkg::PIN_CTRL_OFS: begin
                if (IS_UPSTREAM) begin                                             // R9
                    for (int p = 0; p < NPIN; p++) begin                           // R14
                        v[p*sdg_pkg::PIN_STRIDE + sdg_pkg::PIN_IN_BIT]  = pin_in_reg[p];
                        v[p*sdg_pkg::PIN_STRIDE + sdg_pkg::PIN_OE_BIT]  = oe_reg[p];
                        v[p*sdg_pkg::PIN_STRIDE + sdg_pkg::PIN_OUT_BIT] = out_reg[p];
                    end
                end
            end
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : rd_view

    // =====================================================
    // register writes and identity loading
    always_comb begin
        dbg_ctrl_next = dbg_ctrl_reg;
        ss_id_next    = ss_id_reg;
        oe_next       = oe_reg;
        out_next      = out_reg;
        // config first so a same-cycle sideband write wins
        if (cfg_wr && i_cfg_addr == sdg_pkg::DBG_CTRL_OFS)
            dbg_ctrl_next = i_cfg_wdata[6:0];                                     // R1 R2 R3 R13
        if (smb_wr && i_smb_addr == sdg_pkg::DBG_CTRL_OFS)
            dbg_ctrl_next = i_smb_wdata[6:0];
        for (int p = 0; p < NPIN; p++) begin
            if (IS_UPSTREAM && cfg_wr && i_cfg_addr == sdg_pkg::PIN_CTRL_OFS) begin // R9
                oe_next[p]  = i_cfg_wdata[p*sdg_pkg::PIN_STRIDE + sdg_pkg::PIN_OE_BIT];  // R11
                out_next[p] = i_cfg_wdata[p*sdg_pkg::PIN_STRIDE + sdg_pkg::PIN_OUT_BIT]; // R12
            end
            if (IS_UPSTREAM && smb_wr && i_smb_addr == sdg_pkg::PIN_CTRL_OFS) begin
                oe_next[p]  = i_smb_wdata[p*sdg_pkg::PIN_STRIDE + sdg_pkg::PIN_OE_BIT];
                out_next[p] = i_smb_wdata[p*sdg_pkg::PIN_STRIDE + sdg_pkg::PIN_OUT_BIT];
            end
        end
        // identity is read-only to config; sideband and eeprom may replace it
        if (i_ee_load)
            ss_id_next = i_ee_ident;                                              // R7 R8
        if (smb_wr && i_smb_addr == sdg_pkg::SS_IDENT_OFS)
            ss_id_next = i_smb_wdata;                                             // R7 R8
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            dbg_ctrl_reg <= sdg_pkg::DBG_CTRL_RST;
            ss_id_reg    <= {DEVICE_RST, VENDOR_RST};
            oe_reg       <= NPIN'(sdg_pkg::PIN_OE_RST);
            out_reg      <= NPIN'(sdg_pkg::PIN_OUT_RST);
        end else begin
            dbg_ctrl_reg <= dbg_ctrl_next;
            ss_id_reg    <= ss_id_next;
            oe_reg       <= oe_next;
            out_reg      <= out_next;
        end
    end

    // =====================================================
    // pin input sampling: three stages, accept when last two agree
    always_comb begin
        pin_in_next = pin_in_reg;
        for (int p = 0; p < NPIN; p++)
            if (sync2_reg[p] == sync3_reg[p])
                pin_in_next[p] = sync3_reg[p];                                    // R10
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            sync1_reg  <= '0;
            sync2_reg  <= '0;
            sync3_reg  <= '0;
            pin_in_reg <= '0;
        end else begin
            sync1_reg  <= i_gpio_in;
            sync2_reg  <= sync1_reg;
            sync3_reg  <= sync2_reg;
            pin_in_reg <= pin_in_next;
        end
    end

    assign o_gpio_oe  = oe_reg;                                                   // R11
    assign o_gpio_out = out_reg;                                                  // R12

    // =====================================================
    // trace capture; reserved trigger codes never match a real state
    assign trace_word = i_trace_src[32*dbg_ctrl_reg[1:0] +: 32];                  // R1 R16
    assign trig_hit   = dbg_ctrl_reg[5:2] != sdg_pkg::SDG_ST_NONE
                        && dbg_ctrl_reg[5:2] <= sdg_pkg::SDG_ST_RECOVERY
                        && i_link_state == dbg_ctrl_reg[5:2];                     // R2
    // capture stops when full so the oldest words after the trigger survive
    assign push       = !dbg_ctrl_reg[sdg_pkg::DBG_CLR_BIT] && !full
                        && (armed_reg || trig_hit);                               // R16
    assign pop        = i_smb_req && !i_smb_wr && i_smb_addr == sdg_pkg::DBG_DATA_OFS
                        && !empty && !dbg_ctrl_reg[sdg_pkg::DBG_CLR_BIT];         // R4

    always_comb begin
        armed_next  = armed_reg || trig_hit;
        wr_ptr_next = push ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
        rd_ptr_next = pop  ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
        cnt_next    = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        // clear holds the buffer empty and disarmed while set
        if (dbg_ctrl_reg[sdg_pkg::DBG_CLR_BIT]) begin                             // R3
            armed_next  = 1'b0;
            wr_ptr_next = '0;
            rd_ptr_next = '0;
            cnt_next    = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            armed_reg  <= 1'b0;
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            armed_reg  <= armed_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg    <= cnt_next;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (push)
            trace_mem[wr_ptr_reg] <= trace_word;                                  // R16
    end

    // =====================================================
    // answers, one cycle after each request
    always_comb begin
        cfg_rd_next = cfg_rd_reg;
        smb_rd_next = smb_rd_reg;
        if (i_cfg_req && !i_cfg_wr)
            cfg_rd_next = rd_view(i_cfg_addr, 1'b0);                              // R4
        if (i_smb_req && !i_smb_wr)
            smb_rd_next = rd_view(i_smb_addr, 1'b1);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cfg_rd_reg  <= '0;
            smb_rd_reg  <= '0;
            cfg_ack_reg <= 1'b0;
            smb_ack_reg <= 1'b0;
        end else begin
            cfg_rd_reg  <= cfg_rd_next;
            smb_rd_reg  <= smb_rd_next;
            cfg_ack_reg <= i_cfg_req;
            smb_ack_reg <= i_smb_req;
        end
    end

    assign o_cfg_rdata = cfg_rd_reg;
    assign o_cfg_ack   = cfg_ack_reg;
    assign o_smb_rdata = smb_rd_reg;
    assign o_smb_ack   = smb_ack_reg;

    // =====================================================
    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    sequence cfg_read_s(logic [7:0] a);
        i_cfg_req && !i_cfg_wr && i_cfg_addr == a && !i_smb_req;
    endsequence

    ctrl_write_a: assert property (cfg_wr && i_cfg_addr == sdg_pkg::DBG_CTRL_OFS && !smb_wr // R1
        |=> dbg_ctrl_reg[5:0] == $past(i_cfg_wdata[5:0]))
        else $error("debug control write lost");
    clear_empties_a: assert property (dbg_ctrl_reg[sdg_pkg::DBG_CLR_BIT] // R3
        |=> cnt_reg == '0 && !armed_reg)
        else $error("clear did not empty trace buffer");
    data_hidden_a: assert property (cfg_read_s(sdg_pkg::DBG_DATA_OFS) // R4
        && !dbg_ctrl_reg[sdg_pkg::DBG_CLR_BIT]
        |=> o_cfg_ack && o_cfg_rdata == 32'h0000_0000 && $stable(rd_ptr_reg))
        else $error("trace data visible on config path");
    cap_header_a: assert property (cfg_read_s(sdg_pkg::CAP_HDR_OFS) // R5
        |=> o_cfg_rdata == 32'h0000_c00d)
        else $error("capability header wrong");
    ident_ro_a: assert property (!i_ee_load && !smb_wr ##1 !i_ee_load && !smb_wr // R7
        |=> $stable(ss_id_reg))
        else $error("identity changed without load");
    pin_sample_a: assert property (sync2_reg == sync3_reg // R10
        |=> pin_in_reg == $past(sync3_reg))
        else $error("pin input not sampled");
    pin_drive_a: assert property (IS_UPSTREAM && cfg_wr && !smb_wr // R12
        && i_cfg_addr == sdg_pkg::PIN_CTRL_OFS
        |=> o_gpio_oe[1] == $past(i_cfg_wdata[5])
        && o_gpio_out[7] == $past(i_cfg_wdata[30]))
        else $error("pin control write not driven");
    rsvd_zero_a: assert property (cfg_read_s(sdg_pkg::PIN_CTRL_OFS) // R15
        |=> o_cfg_rdata[3] == 1'b0 && o_cfg_rdata[31] == 1'b0)
        else $error("reserved pin bit reads non-zero");
    capture_start_a: assert property (trig_hit && !full && !dbg_ctrl_reg[6] && !pop // R16
        |=> cnt_reg == $past(cnt_reg) + 1'b1 ##1 armed_reg || dbg_ctrl_reg[6])
        else $error("trigger did not start capture");
endmodule : sdg_regs

/* dv/sdg_far_end.sv */
`timescale 1ns/1ns
// =====================================================
// pin pads with pull-ups and the four trace sources
module sdg_far_end (
    input  wire logic [7:0]   i_gpio_out,   // device drive value
    input  wire logic [7:0]   i_gpio_oe,    // device drive enable
    output logic      [7:0]   o_gpio_pad,   // resolved pad level
    output logic      [127:0] o_trace_src   // trace source words
);
    // an undriven pad settles high through its pull-up, never at a stale level
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            o_gpio_pad[k] = i_gpio_oe[k] ? i_gpio_out[k] : 1'b1;
        end
        // each source carries its own number so a wrong select shows up
        for (int n = 0; n < 4; n++) begin
            o_trace_src[32*n +: 32] = 32'h7ace0000 + 32'(n);
        end
    end
endmodule : sdg_far_end

/* dv/switch_debug_subsys_gpio_regs_test.sv */
`timescale 1ns/1ns
module switch_debug_subsys_gpio_regs_test;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         cfg_req = 1'b0, cfg_wr = 1'b0, smb_req = 1'b0, smb_wr = 1'b0;
    logic [7:0]   cfg_addr = 8'h00, smb_addr = 8'h00;
    logic [31:0]  cfg_wdata = 32'h0, smb_wdata = 32'h0, cfg_rdata, smb_rdata;
    logic         cfg_ack, smb_ack, ee_load = 1'b0;
    logic [31:0]  ee_ident = 32'h0;
    logic [3:0]   link_state = 4'h0;
    logic [127:0] trace_src;
    logic [7:0]   gpio_in, gpio_out, gpio_oe;
    int           err_count = 0;
    int           samples_checked = 0;

    always #4 clk = ~clk;

    sdg_regs #(.DEPTH(16), .NPIN(8), .IS_UPSTREAM(1'b1),
        .VENDOR_RST(16'h5a5a), .DEVICE_RST(16'ha5a5)) DUT ( // arbitrary identity values
        .i_clk_sys(clk), .i_rst_n(rst_n),
        .i_cfg_req(cfg_req), .i_cfg_wr(cfg_wr), .i_cfg_addr(cfg_addr),
        .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata), .o_cfg_ack(cfg_ack),
        .i_smb_req(smb_req), .i_smb_wr(smb_wr), .i_smb_addr(smb_addr),
        .i_smb_wdata(smb_wdata), .o_smb_rdata(smb_rdata), .o_smb_ack(smb_ack),
        .i_ee_load(ee_load), .i_ee_ident(ee_ident), .i_link_state(link_state),
        .i_trace_src(trace_src), .i_gpio_in(gpio_in), .o_gpio_out(gpio_out),
        .o_gpio_oe(gpio_oe));

    sdg_far_end far (.i_gpio_out(gpio_out), .i_gpio_oe(gpio_oe),
        .o_gpio_pad(gpio_in), .o_trace_src(trace_src));

    // =====================================================
    // checking and closing
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // =====================================================
    // one access: request held for one cycle, answer due exactly one cycle later
    task automatic access(input bit smb, input bit wr, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        @(negedge clk);
        cfg_req = !smb;
        smb_req = smb;
        cfg_wr = wr;
        smb_wr = wr;
        cfg_addr = a;
        smb_addr = a;
        cfg_wdata = d;
        smb_wdata = d;
        @(negedge clk);
        cfg_req = 1'b0;
        smb_req = 1'b0;
        q = smb ? smb_rdata : cfg_rdata;
        check("ack", {31'h0, smb ? smb_ack : cfg_ack}, 32'h1);
    endtask : access

    task automatic wr(input bit smb, input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        access(smb, 1'b1, a, d, q);
    endtask : wr

    task automatic rd(input bit smb, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        access(smb, 1'b0, a, 32'h0, q);
        check($sformatf("read %h", a), q, exp);
    endtask : rd

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    // =====================================================
    // main sequence
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        rd(0, 8'h9c, 32'h0);
        rd(0, 8'hb0, 32'h0000c00d);
        rd(1, 8'hb4, 32'ha5a55a5a);
        rd(0, 8'hb8, 32'h11111111);
        rd(0, 8'ha0, 32'h0);
        wr(0, 8'hb0, 32'hffffffff);
        rd(0, 8'hb0, 32'h0000c00d);
        wr(0, 8'h9c, 32'hffffffff);
        rd(1, 8'h9c, 32'h0000007f);
        // identity is read-only on the config path but loadable otherwise
        wr(0, 8'hb4, 32'h12345678);
        rd(0, 8'hb4, 32'ha5a55a5a);
        wr(1, 8'hb4, 32'h13572468);
        rd(0, 8'hb4, 32'h13572468);
        ee_ident = 32'hbeef4321;
        @(negedge clk);
        ee_load = 1'b1;
        @(negedge clk);
        ee_load = 1'b0;
        rd(0, 8'hb4, 32'hbeef4321);
        // even pins float high with out set, odd pins drive low
        wr(0, 8'hb8, 32'h2c2c2c2c);
        check("oe", {24'h0, gpio_oe}, 32'haa);
        check("out", {24'h0, gpio_out}, 32'h55);
        repeat (6) @(negedge clk);
        rd(1, 8'hb8, 32'h25252525);
        // every real-state trigger code, 1 to 11; each source change exposes a missed clear
        for (int c = 1; c <= 11; c++) begin
            wr(0, 8'h9c, 32'h40);
            link_state = 4'(c);
            wr(1, 8'h9c, 32'((c << 2) | (c % 4)));
            repeat (2) @(negedge clk);
            rd(1, 8'hac, 32'h7ace0000 + 32'(c % 4));
            rd(0, 8'hac, 32'h0);
            link_state = 4'h0;
        end
        // capture only pauses while full, so the armed buffer refills after each pop
        for (int k = 0; k < 15; k++) begin
            rd(1, 8'hac, 32'h7ace0003);
        end
        rd(1, 8'hac, 32'h7ace0003);
        wr(0, 8'h9c, 32'h40);
        rd(1, 8'hac, 32'h0);
        // a reserved trigger code never starts capture, even when the state matches
        link_state = 4'hf;
        wr(1, 8'h9c, 32'h3c);
        repeat (2) @(negedge clk);
        rd(1, 8'hac, 32'h0);
        link_state = 4'h0;
        tally_and_finish();
    end
endmodule : switch_debug_subsys_gpio_regs_test
